// ---- shared/lbp_pkg.sv ----
// Constants, register layout and types for the LED breathing PWM driver
package lbp_pkg;

  // Register offsets
  localparam logic [7:0] REG_SHUTDOWN = 8'h00;
  localparam logic [7:0] REG_BREATH_CTRL = 8'h01;
  localparam logic [7:0] REG_MODE = 8'h02;
  localparam logic [7:0] REG_PEAK_CURRENT = 8'h03;
  localparam logic [7:0] REG_BRIGHTNESS = 8'h04;
  localparam logic [7:0] REG_BRIGHT_COMMIT = 8'h07;
  localparam logic [7:0] REG_OFFSET_TIME = 8'h0A;
  localparam logic [7:0] REG_RISE_HOLD = 8'h10;
  localparam logic [7:0] REG_FALL_OFF = 8'h16;
  localparam logic [7:0] REG_TIME_COMMIT = 8'h1C;
  localparam logic [7:0] REG_OUTPUT_GATE = 8'h1D;
  localparam logic [7:0] REG_SOFT_RESET = 8'h2F;

  // Data value that triggers commit and soft reset
  localparam logic [7:0] ACTION_CODE = 8'h00;
  // Slave address byte with write bit
  localparam logic [7:0] DEV_WRITE_ADDR = 8'hD0;

  // Field positions
  localparam int CH_EN_BIT = 5;
  localparam int SSD_BIT = 0;
  localparam int RAMP_STOP_BIT = 5;
  localparam int HOLD_SEL_BIT = 4;
  localparam int MODE_BIT = 5;
  localparam int PEAK_LSB = 2;
  localparam int OFFSET_LSB = 4;
  localparam int RISE_LSB = 5;
  localparam int HOLD_LSB = 1;
  localparam int FALL_LSB = 5;
  localparam int DARK_LSB = 1;
  localparam int BRIGHT_COARSE_LSB = 1;
  localparam int GATE_BIT = 0;

  // Highest valid codes of the time fields; the ramp limit applies to the rise/fall code plus one
  localparam logic [3:0] MAX_LONG_CODE = 4'hA;
  localparam logic [3:0] MAX_HOLD_CODE = 4'h8;
  localparam logic [3:0] MAX_RAMP_CODE = 4'h8;

  // Timing: one time unit is split into ramp steps
  localparam int UNIT_TIME_US = 130000;
  localparam int CLK_FREQ_MHZ = 125;
  localparam int RAMP_STEPS = 128;
  localparam int RAMP_SHIFT = 7;
  localparam int STEP_CYCLES = UNIT_TIME_US * CLK_FREQ_MHZ / RAMP_STEPS;

  typedef enum logic [2:0] {PH_IDLE, PH_OFFSET, PH_RISE, PH_HOLD, PH_FALL, PH_DARK} lbp_phase_t;

  typedef struct packed {
    logic ch_en;
    logic soft_shutdown_bit;
    logic ramp_stop_enable;
    logic hold_phase_select;
    logic breath_mode;
    logic [2:0] peak_current;
    logic [7:0] bright_sh;
    logic [7:0] bright_act;
    logic [3:0] offset_sh;
    logic [2:0] rise_sh;
    logic [3:0] hold_sh;
    logic [2:0] fall_sh;
    logic [3:0] dark_sh;
    logic [3:0] offset_act;
    logic [2:0] rise_act;
    logic [3:0] hold_act;
    logic [2:0] fall_act;
    logic [3:0] dark_act;
    logic out_gate;
  } lbp_regs_t;

  localparam lbp_regs_t REGS_RST = '{soft_shutdown_bit: 1'b1, out_gate: 1'b1, default: '0};

endpackage : lbp_pkg

// ---- verilog/lbp_driver.sv ----
// LED breathing PWM driver: byte-level write link, register file, breathing sequencer and PWM
//
// Functional notes
// - Mode bit 0 selects direct PWM; duty follows brightness, no breathing.
// - Mode bit 1 runs breathing using the five phase durations.
// - Peak current code in bits 4:2 selects output level, 1xx gives 17.5mA.
// - Direct mode duty is full 8-bit brightness over 256 steps.
// - Breathing uses brightness bits 7:1 as peak in 128 steps.
// - Brightness writes go to shadow, applied when commit register gets zero.
// - Direct mode duty changes only after a new committed brightness.
// - Offset code 0 is zero, then 0.13s doubling to 66.56s; others invalid.
// - Rise code 0.13s doubling to 16.64s; hold zero then doubling to 16.64s.
// - Fall encodes like rise; dark time encodes like offset.
// - Three timing registers shadowed, applied together on zero to timing commit.
// - Output gate bit 0 forces LED off when 0; resets to 1.
// - Writing zero to soft reset restores every register default.
// - Power-up loads defaults and the output stays dark.
// - Offset phase runs once at sequence start only.
// - Rise, hold, fall, dark repeat while breathing and ramp-stop off.
// - Ramp-stop on runs the sequence once then halts in selected phase.
// - Ramp-stop with hold select 0 stays in hold at peak.
// - Ramp-stop with hold select 1 finishes fall, then stays dark.
// - Shutdown leaves every register unchanged.
// - Soft shutdown bit 1 switches the output off.
// - Low shutdown pin puts device in hardware shutdown.
// - Shutdown register bit 5 enables channel, bit 0 soft shutdown, resets 1.
// - Breathing control bit 5 ramp-stop, bit 4 hold select, both reset 0.
// - Write-only link at address 1101000; pointer increments after each data byte.
`timescale 1ns/1ps

module lbp_driver #(
  parameter int STEP_CYCLES = lbp_pkg::STEP_CYCLES
) (
  input wire logic mclk, // System clock, 125 MHz
  input wire logic rstn, // Asynchronous reset, active low
  input wire logic link_clk, // Clock of the byte link front end
  input wire logic link_frame, // High from start to stop condition
  input wire logic link_byte_valid, // One-cycle strobe, byte received
  input wire logic [7:0] link_byte, // Received byte
  output logic link_ack, // Byte acknowledged, one link cycle
  input wire logic shutdown_pin_n, // Hardware shutdown pin, active low
  output logic led_drive, // PWM on/off for the current source
  output logic [2:0] peak_current_sel // Peak current code for the analog source
);

  localparam logic [23:0] STEP_LAST = 24'(STEP_CYCLES - 1);

  typedef struct packed {
    logic [1:0] nbyte;
    logic addr_ok;
    logic [7:0] ptr;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic req_tog;
    logic ack;
  } lbp_link_t;

  typedef struct packed {
    logic pin_s1;
    logic pin_s2;
    logic tog_s1;
    logic tog_s2;
    logic tog_s3;
    lbp_pkg::lbp_regs_t regs;
    lbp_pkg::lbp_phase_t phase;
    logic [16:0] elapsed;
    logic [23:0] step_cnt;
    logic [7:0] pwm_cnt;
    logic led;
  } lbp_core_t;

  localparam lbp_link_t LINK_RST = '0;
  localparam lbp_core_t CORE_RST = '{regs: lbp_pkg::REGS_RST, phase: lbp_pkg::PH_IDLE, default: '0};

  // Phase length in ramp steps; zero for code 0 or an invalid code
  function automatic logic [16:0] span_steps(input logic [3:0] code, input logic [3:0] max_code);
    logic [16:0] base;
    base = 17'(lbp_pkg::RAMP_STEPS);
    if (code == 4'h0 || code > max_code) begin
      span_steps = 17'h00000;
    end else begin
      span_steps = base << (code - 4'h1);
    end
  endfunction : span_steps

  // Rise and fall codes have no zero setting: code n lasts 2^n units
  function automatic logic [16:0] ramp_span(input logic [2:0] code);
    ramp_span = span_steps(4'({1'b0, code}) + 4'h1, lbp_pkg::MAX_RAMP_CODE);
  endfunction : ramp_span

  // Peak scaled by num / ramp length; length is a power of two so a shift divides
  function automatic logic [6:0] ramp_level(input logic [6:0] peak, input logic [16:0] num, input logic [2:0] code);
    logic [23:0] prod;
    logic [4:0] sh;
    prod = 24'(peak) * 24'(num);
    sh = 5'(lbp_pkg::RAMP_SHIFT) + 5'(code);
    ramp_level = 7'(prod >> sh);
  endfunction : ramp_level

  // ---------------- Link domain ----------------
  lbp_link_t lq, ln;

  always_comb begin
    ln = lq;
    ln.ack = 1'b0;
    if (!link_frame) begin
      ln.nbyte = 2'h0;
      ln.addr_ok = 1'b0;
    end else if (link_byte_valid) begin
      case (lq.nbyte)
        2'h0: begin
          ln.addr_ok = (link_byte == lbp_pkg::DEV_WRITE_ADDR);
          ln.ack = (link_byte == lbp_pkg::DEV_WRITE_ADDR);
          ln.nbyte = 2'h1;
        end
        2'h1: begin
          if (lq.addr_ok) begin
            ln.ptr = link_byte;
            ln.ack = 1'b1;
          end
          ln.nbyte = 2'h2;
        end
        default: begin
          if (lq.addr_ok) begin
            ln.wr_addr = lq.ptr;
            ln.wr_data = link_byte;
            ln.req_tog = ~lq.req_tog;
            ln.ptr = lq.ptr + 8'h01;
            ln.ack = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      lq <= LINK_RST;
    end else begin
      lq <= ln;
    end
  end

  assign link_ack = lq.ack;

  // ---------------- System domain ----------------
  lbp_core_t q, n;
  logic wr_evt;
  logic step_tick;
  logic stay;
  logic phase_done;
  logic [16:0] len_offset, len_rise, len_hold, len_fall, len_dark, phase_len;
  logic [6:0] peak;
  logic [6:0] level;
  logic [7:0] duty;
  logic [7:0] wd;

  always_comb begin
    n = q;
    // Two-stage synchronisers; stage one feeds stage two only
    n.pin_s1 = shutdown_pin_n;
    n.pin_s2 = q.pin_s1;
    n.tog_s1 = lq.req_tog;
    n.tog_s2 = q.tog_s1;
    n.tog_s3 = q.tog_s2;
    // Address and data were settled a full sync delay before the toggle is seen
    wr_evt = q.tog_s2 ^ q.tog_s3;
    wd = lq.wr_data;

    if (wr_evt) begin
      case (lq.wr_addr)
        lbp_pkg::REG_SHUTDOWN: begin
          n.regs.ch_en = wd[lbp_pkg::CH_EN_BIT];
          n.regs.soft_shutdown_bit = wd[lbp_pkg::SSD_BIT];
        end
        lbp_pkg::REG_BREATH_CTRL: begin
          n.regs.ramp_stop_enable = wd[lbp_pkg::RAMP_STOP_BIT];
          n.regs.hold_phase_select = wd[lbp_pkg::HOLD_SEL_BIT];
        end
        lbp_pkg::REG_MODE: n.regs.breath_mode = wd[lbp_pkg::MODE_BIT];
        lbp_pkg::REG_PEAK_CURRENT: n.regs.peak_current = wd[lbp_pkg::PEAK_LSB +: 3];
        lbp_pkg::REG_BRIGHTNESS: n.regs.bright_sh = wd;
        lbp_pkg::REG_BRIGHT_COMMIT: begin
          if (wd == lbp_pkg::ACTION_CODE) begin
            n.regs.bright_act = q.regs.bright_sh;
          end
        end
        lbp_pkg::REG_OFFSET_TIME: n.regs.offset_sh = wd[lbp_pkg::OFFSET_LSB +: 4];
        lbp_pkg::REG_RISE_HOLD: begin
          n.regs.rise_sh = wd[lbp_pkg::RISE_LSB +: 3];
          n.regs.hold_sh = wd[lbp_pkg::HOLD_LSB +: 4];
        end
        lbp_pkg::REG_FALL_OFF: begin
          n.regs.fall_sh = wd[lbp_pkg::FALL_LSB +: 3];
          n.regs.dark_sh = wd[lbp_pkg::DARK_LSB +: 4];
        end
        lbp_pkg::REG_TIME_COMMIT: begin
          if (wd == lbp_pkg::ACTION_CODE) begin
            n.regs.offset_act = q.regs.offset_sh;
            n.regs.rise_act = q.regs.rise_sh;
            n.regs.hold_act = q.regs.hold_sh;
            n.regs.fall_act = q.regs.fall_sh;
            n.regs.dark_act = q.regs.dark_sh;
          end
        end
        lbp_pkg::REG_OUTPUT_GATE: n.regs.out_gate = wd[lbp_pkg::GATE_BIT];
        lbp_pkg::REG_SOFT_RESET: begin
          if (wd == lbp_pkg::ACTION_CODE) begin
            n.regs = lbp_pkg::REGS_RST;
          end
        end
        default: begin
        end
      endcase
    end

    // Phase lengths in ramp steps
    len_offset = span_steps(q.regs.offset_act, lbp_pkg::MAX_LONG_CODE);
    len_rise = ramp_span(q.regs.rise_act);
    len_hold = span_steps(q.regs.hold_act, lbp_pkg::MAX_HOLD_CODE);
    len_fall = ramp_span(q.regs.fall_act);
    len_dark = span_steps(q.regs.dark_act, lbp_pkg::MAX_LONG_CODE);

    step_tick = (q.step_cnt == STEP_LAST);
    n.step_cnt = step_tick ? 24'h000000 : q.step_cnt + 24'h000001;

    case (q.phase)
      lbp_pkg::PH_OFFSET: phase_len = len_offset;
      lbp_pkg::PH_RISE: phase_len = len_rise;
      lbp_pkg::PH_HOLD: phase_len = len_hold;
      lbp_pkg::PH_FALL: phase_len = len_fall;
      lbp_pkg::PH_DARK: phase_len = len_dark;
      default: phase_len = 17'h00000;
    endcase

    stay = q.regs.ramp_stop_enable &&
           ((q.phase == lbp_pkg::PH_HOLD && !q.regs.hold_phase_select) ||
            (q.phase == lbp_pkg::PH_DARK && q.regs.hold_phase_select));
    phase_done = (phase_len == 17'h00000) || (step_tick && (q.elapsed == phase_len - 17'h00001));

    if (!q.regs.breath_mode) begin
      n.phase = lbp_pkg::PH_IDLE;
      n.elapsed = 17'h00000;
    end else if (q.phase == lbp_pkg::PH_IDLE) begin
      n.phase = lbp_pkg::PH_OFFSET;
      n.elapsed = 17'h00000;
    end else if (stay) begin
      n.elapsed = q.elapsed;
    end else if (phase_done) begin
      n.elapsed = 17'h00000;
      case (q.phase)
        lbp_pkg::PH_OFFSET: n.phase = lbp_pkg::PH_RISE;
        lbp_pkg::PH_RISE: n.phase = lbp_pkg::PH_HOLD;
        lbp_pkg::PH_HOLD: n.phase = lbp_pkg::PH_FALL;
        lbp_pkg::PH_FALL: n.phase = lbp_pkg::PH_DARK;
        lbp_pkg::PH_DARK: n.phase = lbp_pkg::PH_RISE;
        default: n.phase = lbp_pkg::PH_IDLE;
      endcase
    end else if (step_tick) begin
      n.elapsed = q.elapsed + 17'h00001;
    end

    peak = q.regs.bright_act[lbp_pkg::BRIGHT_COARSE_LSB +: 7];
    case (q.phase)
      lbp_pkg::PH_RISE: level = ramp_level(peak, q.elapsed, q.regs.rise_act);
      lbp_pkg::PH_HOLD: level = peak;
      lbp_pkg::PH_FALL: level = ramp_level(peak, len_fall - q.elapsed, q.regs.fall_act);
      default: level = 7'h00;
    endcase

    // Breathing level uses the upper seven duty bits so both modes share one counter
    duty = q.regs.breath_mode ? {level, 1'b0} : q.regs.bright_act;

    n.pwm_cnt = q.pwm_cnt + 8'h01;
    n.led = (q.pwm_cnt < duty) && q.regs.out_gate && q.regs.ch_en &&
            !q.regs.soft_shutdown_bit && q.pin_s2;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q <= CORE_RST;
    end else begin
      q <= n;
    end
  end

  assign led_drive = q.led;
  assign peak_current_sel = q.regs.peak_current;

endmodule : lbp_driver

// ---- test/lbp_driver_monitor.sv ----
// Port checker for the LED breathing PWM driver
`timescale 1ns/1ps
module lbp_driver_monitor (
  input wire logic mclk, // System clock
  input wire logic rstn, // Reset, active low
  input wire logic link_clk, // Link clock
  input wire logic link_frame, // Frame level
  input wire logic link_byte_valid, // Byte strobe
  input wire logic [7:0] link_byte, // Byte data
  input wire logic link_ack, // Byte acknowledge
  input wire logic shutdown_pin_n, // Shutdown pin, active low
  input wire logic led_drive, // PWM output
  input wire logic [2:0] peak_current_sel // Peak current code
);
  logic [7:0] bcnt_r;
  logic addr_ok_r;
  logic [8:0] hi_r;
  logic [3:0] up_r;
  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      bcnt_r <= 8'h00;
      addr_ok_r <= 1'b0;
    end else if (!link_frame) begin
      bcnt_r <= 8'h00;
      addr_ok_r <= 1'b0;
    end else if (link_byte_valid) begin
      bcnt_r <= (bcnt_r == 8'hFF) ? bcnt_r : bcnt_r + 8'h01;
      if (bcnt_r == 8'h00) addr_ok_r <= (link_byte == lbp_pkg::DEV_WRITE_ADDR);
    end
  end
  // Counters: run length of a high output (wraps), cycles since reset (saturates)
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hi_r <= 9'h000;
      up_r <= 4'h0;
    end else begin
      hi_r <= led_drive ? hi_r + 9'h001 : 9'h000;
      up_r <= (up_r == 4'hF) ? up_r : up_r + 4'h1;
    end
  end
  property p_ack_addr;
    @(posedge link_clk) disable iff (!rstn)
    link_frame && link_byte_valid && bcnt_r == 8'h00 && link_byte == lbp_pkg::DEV_WRITE_ADDR |=> link_ack;
  endproperty
  a_ack_addr: assert property (p_ack_addr) else $error("address byte not acked");
  property p_ack_data;
    @(posedge link_clk) disable iff (!rstn)
    link_frame && link_byte_valid && bcnt_r != 8'h00 && addr_ok_r |=> link_ack;
  endproperty
  a_ack_data: assert property (p_ack_data) else $error("data byte not acked");
  property p_ack_silent;
    @(posedge link_clk) disable iff (!rstn)
    link_frame && bcnt_r != 8'h00 && !addr_ok_r |-> !link_ack;
  endproperty
  a_ack_silent: assert property (p_ack_silent) else $error("ack in foreign frame");
  property p_ack_pulse;
    @(posedge link_clk) disable iff (!rstn)
    link_ack |=> !link_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause;
    @(posedge link_clk) disable iff (!rstn)
    link_ack |-> $past(link_byte_valid) && $past(link_frame);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without byte");
  property p_pin_off;
    @(posedge mclk) disable iff (!rstn)
    !shutdown_pin_n [*3] |=> !led_drive;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("output on during pin shutdown");
  property p_hi_max;
    @(posedge mclk) disable iff (!rstn)
    hi_r <= 9'h0FF;
  endproperty
  a_hi_max: assert property (p_hi_max) else $error("output high past full duty");
  property p_reset_dark;
    @(posedge mclk) disable iff (!rstn)
    up_r < 4'hC |-> !led_drive && peak_current_sel == 3'h0;
  endproperty
  a_reset_dark: assert property (p_reset_dark) else $error("output not dark after reset");
  c_led_on: cover property (@(posedge mclk) disable iff (!rstn) $rose(led_drive));
  c_pin: cover property (@(posedge mclk) disable iff (!rstn) $fell(shutdown_pin_n));
  c_bad_frame: cover property (@(posedge link_clk) disable iff (!rstn) link_frame && bcnt_r == 8'h02 && !addr_ok_r);
endmodule : lbp_driver_monitor

bind lbp_driver lbp_driver_monitor mon_u (.mclk(mclk), .rstn(rstn), .link_clk(link_clk),
  .link_frame(link_frame), .link_byte_valid(link_byte_valid), .link_byte(link_byte), .link_ack(link_ack),
  .shutdown_pin_n(shutdown_pin_n), .led_drive(led_drive), .peak_current_sel(peak_current_sel));

// ---- test/lbp_link_host.sv ----
// Byte-level link host standing for the microcontroller
`timescale 1ns/1ps
module lbp_link_host (
  input wire logic link_clk, // Link clock
  output logic link_frame, // Frame level
  output logic link_byte_valid, // Byte strobe
  output logic [7:0] link_byte, // Byte data
  input wire logic link_ack // Acknowledge from the device
);
  initial begin
    link_frame = 1'b0;
    link_byte_valid = 1'b0;
    link_byte = 8'hFF;
  end
  // Data shows the inverse of the last byte between strobes, so a stale value is never taken
  task automatic send(input logic [7:0] q[$], output int acks);
    acks = 0;
    @(negedge link_clk);
    link_frame = 1'b1;
    foreach (q[i]) begin
      @(negedge link_clk);
      link_byte_valid = 1'b1;
      link_byte = q[i];
      @(negedge link_clk);
      link_byte_valid = 1'b0;
      link_byte = ~q[i];
      // Ack rose at the edge that took the byte and stands until the next rising edge
      if (link_ack === 1'b1) acks++;
      @(negedge link_clk);
    end
    link_frame = 1'b0;
    repeat (2) @(negedge link_clk);
  endtask : send
endmodule : lbp_link_host

// ---- test/lbp_driver_tb.sv ----
// Self-checking bench for the LED breathing PWM driver
`timescale 1ns/1ps
module lbp_driver_tb;
  logic mclk, rstn, link_clk, link_frame, link_byte_valid, link_ack, shutdown_pin_n, led_drive;
  logic [7:0] link_byte;
  logic [2:0] peak_current_sel;
  int err_count = 0;
  int checked = 0;
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    link_clk = 1'b0;
    #13;
    forever #40 link_clk = ~link_clk;
  end
  lbp_driver #(.STEP_CYCLES(2)) dut_u (.mclk(mclk), .rstn(rstn), .link_clk(link_clk), .link_frame(link_frame),
    .link_byte_valid(link_byte_valid), .link_byte(link_byte), .link_ack(link_ack),
    .shutdown_pin_n(shutdown_pin_n), .led_drive(led_drive), .peak_current_sel(peak_current_sel));
  lbp_link_host host_u (.link_clk(link_clk), .link_frame(link_frame), .link_byte_valid(link_byte_valid),
    .link_byte(link_byte), .link_ack(link_ack));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] q[$]);
    int acks;
    q.push_front(lbp_pkg::DEV_WRITE_ADDR);
    host_u.send(q, acks);
    chk("ack count", q.size(), acks);
  endtask : wr
  task automatic count(input int n, output int hi);
    hi = 0;
    repeat (n) begin
      @(negedge mclk);
      if (led_drive === 1'b1) hi++;
    end
  endtask : count
  task automatic duty(input logic [31:0] exp, input string what);
    int hi;
    count(256, hi);
    chk(what, exp, hi);
  endtask : duty
  task automatic t_reset;
    duty(0, "dark after reset");
    chk("peak code", 0, peak_current_sel);
  endtask : t_reset
  task automatic t_direct;
    wr({8'h00, 8'h20});
    for (int c = 0; c < 8; c++) begin
      wr({8'h03, 8'(c << 2)});
      chk("peak code", c, peak_current_sel);
    end
    wr({8'h03, 8'h14, 8'h40});
    chk("peak code", 5, peak_current_sel);
    duty(0, "duty before commit");
    wr({8'h07, 8'h00});
    duty(8'h40, "direct duty");
    wr({8'h04, 8'hFF});
    duty(8'h40, "duty held");
    wr({8'h07, 8'h00});
    duty(255, "full duty");
  endtask : t_direct
  task automatic t_gates;
    wr({8'h1D, 8'h00});
    duty(0, "gate off");
    wr({8'h1D, 8'h01, 8'h00, 8'h21});
    wr({8'h00, 8'h21});
    duty(0, "soft shutdown");
    wr({8'h00, 8'h20});
    duty(255, "after soft shutdown");
    shutdown_pin_n = 1'b0;
    repeat (4) @(negedge mclk);
    duty(0, "pin shutdown");
    shutdown_pin_n = 1'b1;
    repeat (4) @(negedge mclk);
    duty(255, "after pin shutdown");
  endtask : t_gates
  task automatic t_bad_addr;
    int acks;
    host_u.send({8'hD2, 8'h04, 8'h00}, acks);
    chk("foreign acks", 0, acks);
    wr({8'h07, 8'h00});
    duty(255, "foreign write dropped");
  endtask : t_bad_addr
  task automatic t_breath;
    int hi;
    wr({8'h04, 8'h81});
    wr({8'h07, 8'h00});
    wr({8'h0A, 8'h10});
    wr({8'h10, 8'h02});
    wr({8'h16, 8'h00});
    wr({8'h1C, 8'h00});
    wr({8'h01, 8'h20});
    wr({8'h02, 8'h20});
    count(128, hi);
    chk("offset dark", 0, hi);
    repeat (700) @(negedge mclk);
    duty((8'h81 >> 1) << 1, "hold at peak");
    wr({8'h01, 8'h30});
    repeat (600) @(negedge mclk);
    duty(0, "stopped dark");
    wr({8'h01, 8'h00});
    count(768, hi);
    chk("cycling", 1, hi > 0 && hi < 768);
  endtask : t_breath
  task automatic t_soft_reset;
    wr({8'h2F, 8'h00});
    duty(0, "dark after soft reset");
    chk("peak code", 0, peak_current_sel);
  endtask : t_soft_reset
  task automatic complete_run;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run
  initial begin
    rstn = 1'b0;
    shutdown_pin_n = 1'b1;
    // Reset spans two link cycles so both domains see it
    repeat (20) @(negedge mclk);
    rstn = 1'b1;
    repeat (30) @(negedge mclk);
    t_reset();
    t_direct();
    t_gates();
    t_bad_addr();
    t_breath();
    t_soft_reset();
    complete_run();
  end
  initial begin
    #400000;
    err_count++;
    complete_run();
  end
endmodule : lbp_driver_tb
